// ==== rtl/cise_pkg.sv ====
// constants, opcode patterns and register map for the instruction subset executor
// assumes a 14-bit instruction word and an 8-bit data path on one 100 MHz clock
//
// What this block does
// - a call pushes the address after the call onto the return stack first
// - a call loads its 11-bit literal into program counter bits 10:0
// - a call fills program counter bits 12:11 from high latch bits 4:3
// - a call takes two cycles and leaves every status flag alone
// - watchdog kick clears the watchdog counter to zero
// - watchdog kick also clears the watchdog prescaler
// - watchdog kick sets the expiry flag and the power-down flag
// - invert writes the complemented file register to W or file, updates zero
// - zero file register writes zero to the addressed register and sets zero
// - file minus one writes file register less one to W or file, updates zero
// - zero accumulator clears W and sets the zero flag
// - count down skip decrements, touches no flag, skips next on zero result
package cise_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W    = 13;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FADR_W  = 7;
  localparam int LIT_W   = 11;
  localparam int STK_DEP = 8;
  localparam int STK_PW  = 3;
  localparam int REGA_W  = 4;
  localparam int WDT_W   = 8;
  localparam int PRE_W   = 8;

  // ----------------------------------------------------------------
  // instruction fields and opcode patterns
  // ----------------------------------------------------------------
  localparam int DEST_BIT  = 7;
  localparam int LAT_HI    = 4;
  localparam int LAT_LO    = 3;
  localparam logic [2:0]  OPC_CALL  = 3'h4;            // word bits 13:11
  localparam logic [5:0]  OPC_INV   = 6'h09;           // word bits 13:8
  localparam logic [5:0]  OPC_DEC   = 6'h03;
  localparam logic [5:0]  OPC_DSKIP = 6'h0b;
  localparam logic [6:0]  OPC_ZFILE = 7'h03;           // word bits 13:7
  localparam logic [6:0]  OPC_ZACC  = 7'h02;
  localparam logic [13:0] OPC_KICK  = 14'h0064;

  // ----------------------------------------------------------------
  // register map and status layout
  // ----------------------------------------------------------------
  localparam logic [REGA_W-1:0] REG_HLATCH = 4'h0;
  localparam logic [REGA_W-1:0] REG_STATUS = 4'h1;
  localparam logic [REGA_W-1:0] REG_ACC    = 4'h2;
  localparam logic [REGA_W-1:0] REG_WDT    = 4'h3;
  localparam logic [REGA_W-1:0] REG_PCLO   = 4'h4;
  localparam logic [REGA_W-1:0] REG_PCHI   = 4'h5;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [4:0]        HLATCH_RST = 5'h00;
  localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE   = 8'h01;
  localparam logic [PC_W-1:0]   PC_ONE     = 13'h0001;

  typedef enum logic [2:0] {
    CISE_OP_NONE, CISE_OP_CALL, CISE_OP_KICK, CISE_OP_INV,
    CISE_OP_ZFILE, CISE_OP_DEC, CISE_OP_ZACC, CISE_OP_DSKIP
  } cise_op_t;

endpackage : cise_pkg

// ==== rtl/cise_file_ram.sv ====
// general file register array, 128 bytes, read without clock, written on clk
// assumes the caller gates writes with the clock enable
`timescale 1ns/1ps
`default_nettype none
module cise_file_ram
  import cise_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  we,
  input  wire logic [FADR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     wdata,
  output logic      [DATA_W-1:0]     rdata
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<FADR_W)-1];

  // read path is combinational so one cycle covers read-modify-write
  assign rdata = mem[addr];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule : cise_file_ram
`default_nettype wire

// ==== rtl/cise_ret_stack.sv ====
// circular return stack, eight entries of 13 bits, push only in this subset
// assumes push is already qualified by the clock enable
`timescale 1ns/1ps
`default_nettype none
module cise_ret_stack
  import cise_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                push,
  input  wire logic [PC_W-1:0]     push_data,
  output logic      [PC_W-1:0]     stack_top
);
  // ----------------------------------------------------------------
  // entries and pointer
  // ----------------------------------------------------------------
  logic [PC_W-1:0]   ent [0:STK_DEP-1];
  logic [STK_PW-1:0] ptr_r;

  // overflow wraps silently, like the real core; oldest entry is lost
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_r <= '0;
    end else if (push) begin
      ptr_r <= ptr_r + 3'h1;
    end
  end

  // entry write
  always_ff @(posedge clk) begin
    if (push) begin
      ent[ptr_r] <= push_data;
    end
  end

  // top is the last written slot
  assign stack_top = ent[ptr_r - 3'h1];
endmodule : cise_ret_stack
`default_nettype wire

// ==== rtl/cise_exec.sv ====
// executor for the call, watchdog kick, file clear/invert/decrement,
// accumulator clear and decrement-skip instructions of an 8-bit core
// assumes program memory returns the word for fetch_addr one cycle later
`timescale 1ns/1ps
`default_nettype none
module cise_exec
  import cise_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  output logic      [cise_pkg::PC_W-1:0]    fetch_addr,
  input  wire logic [cise_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [cise_pkg::REGA_W-1:0]  reg_addr,
  input  wire logic [cise_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [cise_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [cise_pkg::PC_W-1:0]    stack_top,
  output logic      [cise_pkg::WDT_W-1:0]   watchdog_counter,
  output logic                           busy_flush
);
  import cise_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PC_W-1:0]   fetch_addr_r;
  logic [PC_W-1:0]   exec_pc_r;
  logic              flush_r;
  logic [DATA_W-1:0] acc_r;
  logic              zero_flag_r;
  logic              watchdog_expiry_flag_r;
  logic              power_down_flag_r;
  logic [WDT_W-1:0]  wdt_r;
  logic [PRE_W-1:0]  pre_r;
  logic [4:0]        pc_high_latch_r;
  logic [DATA_W-1:0] rdata_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  cise_op_t          op;
  logic [FADR_W-1:0] file_addr;
  logic              dest_file;
  logic [LIT_W-1:0]  lit;
  logic [DATA_W-1:0] file_rdata;
  logic [DATA_W-1:0] alu_res;
  logic              file_we;
  logic              skip;
  logic              take_call;
  logic [PC_W-1:0]   call_target;
  logic [PC_W-1:0]   ret_addr;

  assign file_addr = instr_word[FADR_W-1:0];
  assign dest_file = instr_word[DEST_BIT];
  assign lit       = instr_word[LIT_W-1:0];

  // a flushed word decodes as nothing, so it acts as a no-op slot
  always_comb begin
    op = CISE_OP_NONE;
    if (!flush_r) begin
      if (instr_word[13:11] == OPC_CALL) begin
        op = CISE_OP_CALL;
      end else if (instr_word == OPC_KICK) begin
        op = CISE_OP_KICK;
      end else if (instr_word[13:8] == OPC_INV) begin
        op = CISE_OP_INV;
      end else if (instr_word[13:8] == OPC_DEC) begin
        op = CISE_OP_DEC;
      end else if (instr_word[13:8] == OPC_DSKIP) begin
        op = CISE_OP_DSKIP;
      end else if (instr_word[13:7] == OPC_ZFILE) begin
        op = CISE_OP_ZFILE;
      end else if (instr_word[13:7] == OPC_ZACC) begin
        op = CISE_OP_ZACC;
      end
    end
  end

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  // result of the byte operation, shared by file and accumulator writes
  always_comb begin
    unique case (op)
      CISE_OP_INV:   alu_res = ~file_rdata;
      CISE_OP_DEC:   alu_res = file_rdata - ONE_BYTE;
      CISE_OP_DSKIP: alu_res = file_rdata - ONE_BYTE;
      CISE_OP_ZFILE: alu_res = ZERO_BYTE;
      CISE_OP_ZACC:  alu_res = ZERO_BYTE;
      CISE_OP_NONE,
      CISE_OP_CALL,
      CISE_OP_KICK:  alu_res = file_rdata;
    endcase
  end

  // zero-file always writes; invert, decrement and decrement-skip only when the destination bit is 1
  always_comb begin
    file_we = 1'b0;
    unique case (op)
      CISE_OP_ZFILE: file_we = 1'b1;
      CISE_OP_INV,
      CISE_OP_DEC,
      CISE_OP_DSKIP: file_we = dest_file;
      CISE_OP_NONE,
      CISE_OP_CALL,
      CISE_OP_KICK,
      CISE_OP_ZACC:  file_we = 1'b0;
    endcase
  end

  assign skip        = (op == CISE_OP_DSKIP) && (alu_res == ZERO_BYTE);
  assign take_call   = (op == CISE_OP_CALL);
  assign ret_addr    = exec_pc_r + PC_ONE;
  assign call_target = {pc_high_latch_r[LAT_HI:LAT_LO], lit};

  cise_file_ram u_file_ram (
    .clk   (clk),
    .we    (ce && file_we),
    .addr  (file_addr),
    .wdata (alu_res),
    .rdata (file_rdata)
  );

  // push happens on the same edge the target loads, so the stack sees
  // the old return address before the counter moves
  cise_ret_stack u_ret_stack (
    .clk       (clk),
    .rst_b     (rst_b),
    .push      (ce && take_call),
    .push_data (ret_addr),
    .stack_top (stack_top)
  );

  // ----------------------------------------------------------------
  // program counter and fetch
  // ----------------------------------------------------------------
  // fetch runs one word ahead; exec_pc follows the word now decoded
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fetch_addr_r <= PC_RST;
      exec_pc_r    <= PC_RST;
    end else if (ce) begin
      exec_pc_r <= fetch_addr_r;
      if (take_call) begin
        fetch_addr_r <= call_target;
      end else begin
        fetch_addr_r <= fetch_addr_r + PC_ONE;
      end
    end
  end

  // the word already in flight is dropped after a jump or a skip;
  // the word after reset has no valid address, so it is dropped too
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flush_r <= 1'b1;
    end else if (ce) begin
      flush_r <= take_call || skip;
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_r <= ZERO_BYTE;
    end else if (ce) begin
      if (op == CISE_OP_ZACC) begin
        acc_r <= ZERO_BYTE;
      end else if ((op == CISE_OP_INV || op == CISE_OP_DEC ||
                    op == CISE_OP_DSKIP) && !dest_file) begin
        acc_r <= alu_res;
      end
    end
  end

  // ----------------------------------------------------------------
  // zero flag
  // ----------------------------------------------------------------
  // call, kick and count-down-skip leave it as it is
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      zero_flag_r <= 1'b0;
    end else if (ce) begin
      unique case (op)
        CISE_OP_ZFILE,
        CISE_OP_ZACC:  zero_flag_r <= 1'b1;
        CISE_OP_INV,
        CISE_OP_DEC:   zero_flag_r <= (alu_res == ZERO_BYTE);
        CISE_OP_NONE,
        CISE_OP_CALL,
        CISE_OP_KICK,
        CISE_OP_DSKIP: zero_flag_r <= zero_flag_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter, prescaler and its status flags
  // ----------------------------------------------------------------
  // timeout handling lives elsewhere; here the counter only runs and clears
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_r <= '0;
      wdt_r <= '0;
    end else if (ce) begin
      if (op == CISE_OP_KICK) begin
        pre_r <= '0;
        wdt_r <= '0;
      end else begin
        pre_r <= pre_r + 8'h01;
        if (&pre_r) begin
          wdt_r <= wdt_r + 8'h01;
        end
      end
    end
  end

  // both flags read as one after reset; only the kick touches them here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      watchdog_expiry_flag_r <= 1'b1;
      power_down_flag_r      <= 1'b1;
    end else if (ce && op == CISE_OP_KICK) begin
      watchdog_expiry_flag_r <= 1'b1;
      power_down_flag_r      <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // high latch is the only writable register; upper bits are not stored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc_high_latch_r <= HLATCH_RST;
    end else if (ce && reg_wr && reg_addr == REG_HLATCH) begin
      pc_high_latch_r <= reg_wdata[4:0];
    end
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= ZERO_BYTE;
    end else if (ce) begin
      rdata_r <= ZERO_BYTE;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_HLATCH: rdata_r <= {3'h0, pc_high_latch_r};
          REG_STATUS: begin
            rdata_r        <= ZERO_BYTE;
            rdata_r[ST_Z]  <= zero_flag_r;
            rdata_r[ST_PD] <= power_down_flag_r;
            rdata_r[ST_TO] <= watchdog_expiry_flag_r;
          end
          REG_ACC:    rdata_r <= acc_r;
          REG_WDT:    rdata_r <= wdt_r;
          REG_PCLO:   rdata_r <= exec_pc_r[7:0];
          REG_PCHI:   rdata_r <= {3'h0, exec_pc_r[PC_W-1:8]};
          default:    rdata_r <= ZERO_BYTE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fetch_addr       = fetch_addr_r;
  assign reg_rdata        = rdata_r;
  assign watchdog_counter = wdt_r;
  assign busy_flush       = flush_r;
endmodule : cise_exec
`default_nettype wire

// ==== verification/cise_exec_monitor.sv ====
// checker for the instruction subset executor, watching its ports only
// assumes a bind onto cise_exec and ce held high while a call is in flight
`timescale 1ns/1ps
`default_nettype none
module cise_exec_monitor
  import cise_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         rst_b,
  input wire logic                         ce,
  input wire logic [cise_pkg::PC_W-1:0]    fetch_addr,
  input wire logic [cise_pkg::INSTR_W-1:0] instr_word,
  input wire logic [cise_pkg::REGA_W-1:0]  reg_addr,
  input wire logic [cise_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [cise_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic [cise_pkg::PC_W-1:0]    stack_top,
  input wire logic [cise_pkg::WDT_W-1:0]   watchdog_counter,
  input wire logic                         busy_flush
);
  import cise_pkg::*;
  logic       live_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !live_r);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic       run;
  logic       is_call;
  logic       is_kick;
  logic [4:0] hl_r;
  logic [7:0] sk_r;

  // reset is released in the step of its last edge, so stay off one edge longer
  always_ff @(posedge clk) begin
    live_r <= rst_b;
  end

  // a word only counts when it is not sitting in a flushed slot
  assign run     = ce && !busy_flush;
  assign is_call = run && (instr_word[13:11] == OPC_CALL);
  assign is_kick = run && (instr_word == OPC_KICK);

  // shadow of the high latch, the call reads it and the port hides it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hl_r <= HLATCH_RST;
    end else if (ce && reg_wr && (reg_addr == REG_HLATCH)) begin
      hl_r <= reg_wdata[4:0];
    end
  end

  // cycles since a kick, saturating well short of one prescaler lap
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sk_r <= 8'hc8;
    end else if (is_kick) begin
      sk_r <= 8'h00;
    end else if (ce && (sk_r != 8'hc8)) begin
      sk_r <= sk_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_call_push; is_call |=> stack_top == $past(fetch_addr); endproperty
  a_call_push: assert property (p_call_push) else $error("wrong return address");
  property p_call_low; is_call |=> fetch_addr[10:0] == $past(instr_word[10:0]); endproperty
  a_call_low: assert property (p_call_low) else $error("wrong call target low");
  property p_call_high; is_call |=> fetch_addr[12:11] == $past(hl_r[4:3]); endproperty
  a_call_high: assert property (p_call_high) else $error("wrong call target high");
  property p_call_slot; is_call |=> busy_flush ##1 !busy_flush; endproperty
  a_call_slot: assert property (p_call_slot) else $error("call not two cycles");
  property p_kick_zero; is_kick |=> watchdog_counter == 8'h00; endproperty
  a_kick_zero: assert property (p_kick_zero) else $error("kick left count");
  property p_kick_pre; (sk_r < 8'hc8) |-> watchdog_counter == 8'h00; endproperty
  a_kick_pre: assert property (p_kick_pre) else $error("count moved too soon");
  property p_seq_step; run && !is_call |=> fetch_addr == $past(fetch_addr) + PC_ONE; endproperty
  a_seq_step: assert property (p_seq_step) else $error("fetch did not advance");
  property p_flush_step;
    ce && busy_flush |=> fetch_addr == $past(fetch_addr) + PC_ONE;
  endproperty
  a_flush_step: assert property (p_flush_step) else $error("flush slot jumped");
  property p_flush_cause;
    $rose(busy_flush) |-> $past(is_call || (run && instr_word[13:8] == OPC_DSKIP));
  endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush without cause");
  property p_rd_idle; ce && !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");

  c_call: cover property (is_call);
  c_kick: cover property (is_kick);
  c_skip: cover property (run && instr_word[13:8] == OPC_DSKIP ##1 busy_flush);
endmodule : cise_exec_monitor
`default_nettype wire

// ==== verification/cise_pmem_model.sv ====
// program memory model with one registered read port
// assumes the bench fills mem just before it pulses the core reset
`timescale 1ns/1ps
`default_nettype none
module cise_pmem_model
  import cise_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         ce,
  input  wire logic [cise_pkg::PC_W-1:0]    fetch_addr,
  output logic      [cise_pkg::INSTR_W-1:0] instr_word
);
  import cise_pkg::*;
  logic [INSTR_W-1:0] mem [0:8191]; // whole 13-bit space, no aliasing

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // registered like on-chip flash, so the core has to prefetch
  always_ff @(posedge clk) begin
    if (ce) begin
      instr_word <= mem[fetch_addr];
    end
  end
endmodule : cise_pmem_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench: short programs, then register reads
// assumes package, executor, memory model and monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cise_pkg::*;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                ce = 1'b1;
  logic [REGA_W-1:0]   reg_addr = 4'h0;
  logic [DATA_W-1:0]   reg_wdata = 8'h00;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [PC_W-1:0]     fetch_addr;
  logic [INSTR_W-1:0]  instr_word;
  logic [DATA_W-1:0]   reg_rdata;
  logic [PC_W-1:0]     stack_top;
  logic [WDT_W-1:0]    watchdog_counter;
  logic                busy_flush;
  int                  bad_count = 0;
  int                  comparisons = 0;
  int                  cyc = 0;

  always #5 clk = ~clk;

  cise_exec dut (.clk(clk), .rst_b(rst_b), .ce(ce), .fetch_addr(fetch_addr),
    .instr_word(instr_word), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stack_top(stack_top),
    .watchdog_counter(watchdog_counter), .busy_flush(busy_flush));
  cise_pmem_model pmem (.clk(clk), .ce(ce), .fetch_addr(fetch_addr), .instr_word(instr_word));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // hang guard, the watchdog phase is the longest at about 650 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  task automatic wr(input logic [REGA_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe edge
  task automatic rdc(input logic [REGA_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rdc

  function automatic logic [INSTR_W-1:0] fw(input logic [5:0] op, input logic d,
                                           input logic [6:0] f);
    return {op, d, f};
  endfunction : fw

  // empty words are outside the subset and simply advance the count
  task automatic clr();
    for (int i = 0; i < 8192; i++) begin
      pmem.mem[i] = 14'h0000;
    end
  endtask : clr

  task automatic start();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask : start

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clr();
    repeat (16) @(posedge clk);
    // top file address, invert into file, decrement into W
    pmem.mem[0] = {OPC_ZFILE, 7'h7f};
    pmem.mem[1] = fw(OPC_INV, 1'b1, 7'h7f);
    pmem.mem[2] = fw(OPC_DEC, 1'b0, 7'h7f);
    start();
    repeat (8) @(posedge clk);
    rdc(REG_ACC, 8'hfe);
    rdc(REG_STATUS, 8'h18);
    // zero flag set by file clear, later by accumulator clear
    clr();
    pmem.mem[0] = {OPC_ZFILE, 7'h10};
    pmem.mem[1] = fw(OPC_DEC, 1'b0, 7'h10);
    pmem.mem[2] = {OPC_ZFILE, 7'h11};
    pmem.mem[40] = fw(OPC_INV, 1'b1, 7'h11);
    pmem.mem[41] = {OPC_ZACC, 7'h00};
    start();
    repeat (8) @(posedge clk);
    rdc(REG_ACC, 8'hff);
    rdc(REG_STATUS, 8'h1c);
    repeat (40) @(posedge clk);
    rdc(REG_ACC, 8'h00);
    rdc(REG_STATUS, 8'h1c);
    // count down to zero skips an accumulator clear, zero flag stays low
    clr();
    pmem.mem[0] = {OPC_ZFILE, 7'h20};
    pmem.mem[1] = fw(OPC_DEC, 1'b1, 7'h20);
    pmem.mem[2] = fw(OPC_DEC, 1'b1, 7'h20);
    pmem.mem[3] = fw(OPC_INV, 1'b0, 7'h20);
    pmem.mem[4] = fw(OPC_INV, 1'b1, 7'h20);
    pmem.mem[5] = fw(OPC_DSKIP, 1'b1, 7'h20);
    pmem.mem[6] = {OPC_ZACC, 7'h00};
    start();
    repeat (12) @(posedge clk);
    rdc(REG_ACC, 8'h01);
    rdc(REG_STATUS, 8'h18);
    // nonzero results never skip, and zero flag is left high
    clr();
    pmem.mem[0] = {OPC_ZFILE, 7'h30};
    pmem.mem[1] = fw(OPC_DSKIP, 1'b0, 7'h30);
    pmem.mem[2] = fw(OPC_DSKIP, 1'b1, 7'h30);
    pmem.mem[3] = fw(OPC_DSKIP, 1'b0, 7'h30);
    start();
    repeat (8) @(posedge clk);
    rdc(REG_ACC, 8'hfe);
    rdc(REG_STATUS, 8'h1c);
    // call to the top of a page picked by the latch, next word flushed
    clr();
    pmem.mem[0] = {OPC_ZFILE, 7'h40};
    pmem.mem[1] = fw(OPC_DEC, 1'b0, 7'h40);
    pmem.mem[2] = {OPC_CALL, 11'h7ff};
    pmem.mem[3] = {OPC_ZACC, 7'h00};
    pmem.mem[13'h17ff] = fw(OPC_INV, 1'b1, 7'h40);
    start();
    wr(REG_HLATCH, 8'hf0);
    repeat (8) @(posedge clk);
    #1;
    check(stack_top, 16'h0003);
    rdc(REG_PCHI, 8'h18);
    rdc(REG_ACC, 8'hff);
    rdc(REG_HLATCH, 8'h10);
    rdc(4'hf, 8'h00);
    wr(REG_STATUS, 8'h00);
    rdc(REG_STATUS, 8'h18);
    // kick placed so a stale prescaler would wrap soon after it
    clr();
    pmem.mem[454] = OPC_KICK;
    start();
    repeat (400) @(posedge clk);
    ce <= 1'b0;
    #1;
    check(watchdog_counter, 16'h0001);
    // twenty frozen edges: fetch must hold at 400 and the kick slides along
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    #1;
    check(fetch_addr, 16'h0190);
    repeat (200) @(posedge clk);
    #1;
    check(watchdog_counter, 16'h0000);
    rdc(REG_WDT, 8'h00);
    rdc(REG_STATUS, 8'h18);
    results();
  end
endmodule : testbench

bind cise_exec cise_exec_monitor u_mon (.clk(clk), .rst_b(rst_b), .ce(ce),
  .fetch_addr(fetch_addr), .instr_word(instr_word), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stack_top(stack_top), .watchdog_counter(watchdog_counter), .busy_flush(busy_flush));
`default_nettype wire
